// >>> include/csp_map.vh
`ifndef CSP_MAP_VH
`define CSP_MAP_VH
// ****************************************
// Register indices (byte address is index times four)
// ****************************************
`define CSP_IDX_PORT_LATCH 8'h80
`define CSP_IDX_STACK_PTR 8'h81
`define CSP_IDX_PTR_LO 8'h82
`define CSP_IDX_PTR_HI 8'h83
`define CSP_IDX_AUX_ONE 8'h84
`define CSP_IDX_RELOAD 8'h86
`define CSP_IDX_POWER 8'h87
`define CSP_IDX_STACK_CMD 8'h90
`define CSP_IDX_SLEEP 8'h91
`define CSP_IDX_ISTAT 8'h92
`define CSP_IDX_IMASK 8'h93
`define CSP_IDX_SERIAL_VIEW 8'h94
`define CSP_WORD_PAD 2'b00
// ****************************************
// Reset values
// ****************************************
`define CSP_RST_PORT_LATCH 8'hFF
`define CSP_RST_STACK_PTR 8'h07
`define CSP_RST_ZERO 8'h00
`define CSP_RST_POWER 8'h10
// ****************************************
// Power control fields
// ****************************************
`define CSP_PWR_BAUD 7
`define CSP_PWR_FSEL 6
`define CSP_PWR_RSVD 5
`define CSP_PWR_PON_FLAG 4
`define CSP_PWR_USER_ONE 3
`define CSP_PWR_USER_ZERO 2
`define CSP_PWR_DOWN 1
`define CSP_PWR_SLEEP 0
// Bits kept by warm reset: only the power-on flag
`define CSP_PWR_WARM_MASK 8'h10
`define CSP_PWR_WMASK 8'hDF
`define CSP_PWR_SLEEP_CLR 8'hFE
// ****************************************
// Stack command port and events
// ****************************************
`define CSP_STK_CMD_HI 9
`define CSP_STK_CMD_LO 8
`define CSP_STK_PUSH 2'h1
`define CSP_STK_POP 2'h2
`define CSP_STK_STEP 8'h01
`define CSP_BYTE_HI 7
`define CSP_EV_DOWN_ENTER 0
`define CSP_EV_IDLE_ENTER 1
`define CSP_EV_WAKE 2
`define CSP_EV_W 3
`endif

// >>> logic/csp_core_sfr.v
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "csp_map.vh"

// ****************************************
// Plain read-write byte with both resets
// ****************************************
module csp_sfr_byte #(
  parameter DW = 8, // Register width
  parameter [DW-1:0] RST_VAL = `CSP_RST_ZERO // Value after either reset
) (
  input wire ref_clk, // System clock
  input wire arst_n, // Power-on reset, async, active low
  input wire warm_rst_n, // Other resets, synchronous, active low
  input wire wr_en, // Write strobe
  input wire [DW-1:0] wr_data, // Write byte
  output reg [DW-1:0] q // Stored value
);
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= RST_VAL;
    end else if (!warm_rst_n) begin
      q <= RST_VAL;
    end else if (wr_en) begin
      q <= wr_data;
    end
  end
endmodule // csp_sfr_byte

// ****************************************
// Core register bank
// ****************************************
module csp_core_sfr #(
  parameter DW = 8 // SFR width
) (
  input wire ref_clk, // System clock
  input wire arst_n, // Power-on reset, async, active low
  input wire warm_rst_n, // Other resets, synchronous, active low
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pwrite, // APB direction
  input wire [9:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output wire pready, // APB ready
  output reg [31:0] prdata, // APB read data
  output wire pslverr, // APB error, unmapped address
  input wire wake_evt, // Interrupt wake request
  input wire serial_mode_hi_in, // Mode high bit from UART
  input wire framing_err_in, // Framing flag from UART
  output wire [DW-1:0] port_out, // Port latch value
  output wire [15:0] data_pointer, // Active 16-bit pointer
  output wire [DW-1:0] wakeup_reload, // Reload for wake-up timer
  output wire baud_double, // Baud doubling enable
  output wire framing_sel, // Serial bit 7 select
  output wire cpu_clk_en, // CPU clock gate
  output wire periph_clk_en, // Peripheral clock gate
  output wire program_counter_hold, // Program counter suspend
  output wire [DW-1:0] stack_wr_addr, // Address of last push
  output wire irq // Level interrupt
);
  // ****************************************
  // States and storage
  // ****************************************
  localparam ST_RUN = 3'b001;
  localparam ST_IDLE = 3'b010;
  localparam ST_DOWN = 3'b100;
  reg hit;
  reg [DW-1:0] stack_ptr_r;
  reg [DW-1:0] last_push_r;
  reg [DW-1:0] power_r;
  reg ptr_sel_r;
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [`CSP_EV_W-1:0] istat_r;
  reg [`CSP_EV_W-1:0] imask_r;
  wire [DW-1:0] port_latch_q;
  wire [DW-1:0] ptr_lo_pri_q;
  wire [DW-1:0] ptr_hi_pri_q;
  wire [DW-1:0] ptr_lo_sec_q;
  wire [DW-1:0] ptr_hi_sec_q;
  wire [DW-1:0] reload_q;
  // ****************************************
  // Address decode
  // ****************************************
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire warm = ~warm_rst_n;
  wire [DW-1:0] wd = pwdata[DW-1:0];
  wire [1:0] stk_cmd = pwdata[`CSP_STK_CMD_HI:`CSP_STK_CMD_LO];
  wire sel_port = paddr == {`CSP_IDX_PORT_LATCH, `CSP_WORD_PAD};
  wire sel_stack = paddr == {`CSP_IDX_STACK_PTR, `CSP_WORD_PAD};
  wire sel_ptr_lo = paddr == {`CSP_IDX_PTR_LO, `CSP_WORD_PAD};
  wire sel_ptr_hi = paddr == {`CSP_IDX_PTR_HI, `CSP_WORD_PAD};
  wire sel_aux = paddr == {`CSP_IDX_AUX_ONE, `CSP_WORD_PAD};
  wire sel_reload = paddr == {`CSP_IDX_RELOAD, `CSP_WORD_PAD};
  wire sel_power = paddr == {`CSP_IDX_POWER, `CSP_WORD_PAD};
  wire sel_stk_cmd = paddr == {`CSP_IDX_STACK_CMD, `CSP_WORD_PAD};
  wire sel_sleep = paddr == {`CSP_IDX_SLEEP, `CSP_WORD_PAD};
  wire sel_istat = paddr == {`CSP_IDX_ISTAT, `CSP_WORD_PAD};
  wire sel_imask = paddr == {`CSP_IDX_IMASK, `CSP_WORD_PAD};
  wire sel_serial = paddr == {`CSP_IDX_SERIAL_VIEW, `CSP_WORD_PAD};
  wire wr_port = wr & sel_port;
  wire wr_stack = wr & sel_stack;
  wire wr_ptr_lo = wr & sel_ptr_lo;
  wire wr_ptr_hi = wr & sel_ptr_hi;
  wire wr_aux = wr & sel_aux;
  wire wr_reload = wr & sel_reload;
  wire wr_power = wr & sel_power;
  wire wr_stk_cmd = wr & sel_stk_cmd;
  wire wr_istat = wr & sel_istat;
  wire wr_imask = wr & sel_imask;
  // Zero wait states: every access phase completes in one cycle
  assign pready = 1'b1;
  assign pslverr = acc & ~hit;
  // ****************************************
  // Port latch and reload byte
  // ****************************************
  csp_sfr_byte #(
    .DW(DW),
    .RST_VAL(`CSP_RST_PORT_LATCH)
  ) u_port_latch (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .warm_rst_n(warm_rst_n),
    .wr_en(wr_port),
    .wr_data(wd),
    .q(port_latch_q)
  );
  csp_sfr_byte #(
    .DW(DW),
    .RST_VAL(`CSP_RST_ZERO)
  ) u_reload (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .warm_rst_n(warm_rst_n),
    .wr_en(wr_reload),
    .wr_data(wd),
    .q(reload_q)
  );
  // ****************************************
  // Dual data pointer
  // ****************************************
  // Writes land only in the pointer that the select bit makes active
  csp_sfr_byte #(
    .DW(DW),
    .RST_VAL(`CSP_RST_ZERO)
  ) u_ptr_lo_pri (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .warm_rst_n(warm_rst_n),
    .wr_en(wr_ptr_lo & ~ptr_sel_r),
    .wr_data(wd),
    .q(ptr_lo_pri_q)
  );
  csp_sfr_byte #(
    .DW(DW),
    .RST_VAL(`CSP_RST_ZERO)
  ) u_ptr_hi_pri (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .warm_rst_n(warm_rst_n),
    .wr_en(wr_ptr_hi & ~ptr_sel_r),
    .wr_data(wd),
    .q(ptr_hi_pri_q)
  );
  csp_sfr_byte #(
    .DW(DW),
    .RST_VAL(`CSP_RST_ZERO)
  ) u_ptr_lo_sec (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .warm_rst_n(warm_rst_n),
    .wr_en(wr_ptr_lo & ptr_sel_r),
    .wr_data(wd),
    .q(ptr_lo_sec_q)
  );
  csp_sfr_byte #(
    .DW(DW),
    .RST_VAL(`CSP_RST_ZERO)
  ) u_ptr_hi_sec (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .warm_rst_n(warm_rst_n),
    .wr_en(wr_ptr_hi & ptr_sel_r),
    .wr_data(wd),
    .q(ptr_hi_sec_q)
  );
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ptr_sel_r <= 1'b0;
    end else if (warm) begin
      ptr_sel_r <= 1'b0;
    end else if (wr_aux) begin
      ptr_sel_r <= wd[0];
    end
  end
  wire [DW-1:0] ptr_lo_act = ptr_sel_r ? ptr_lo_sec_q : ptr_lo_pri_q;
  wire [DW-1:0] ptr_hi_act = ptr_sel_r ? ptr_hi_sec_q : ptr_hi_pri_q;
  assign data_pointer = {ptr_hi_act, ptr_lo_act};
  // ****************************************
  // Stack pointer
  // ****************************************
  wire [DW-1:0] stack_inc = stack_ptr_r + `CSP_STK_STEP;
  wire [DW-1:0] stack_dec = stack_ptr_r - `CSP_STK_STEP;
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      stack_ptr_r <= `CSP_RST_STACK_PTR;
      last_push_r <= `CSP_RST_ZERO;
    end else if (warm) begin
      stack_ptr_r <= `CSP_RST_STACK_PTR;
      last_push_r <= `CSP_RST_ZERO;
    end else if (wr_stack) begin
      stack_ptr_r <= wd;
    end else if (wr_stk_cmd && stk_cmd == `CSP_STK_PUSH) begin
      // Increment before store: data goes to the new address
      stack_ptr_r <= stack_inc;
      last_push_r <= stack_inc;
    end else if (wr_stk_cmd && stk_cmd == `CSP_STK_POP) begin
      stack_ptr_r <= stack_dec;
    end
  end
  // ****************************************
  // Power control register
  // ****************************************
  // Reserved bit masked off; power-down wins over idle
  wire [DW-1:0] power_masked = wd & `CSP_PWR_WMASK;
  wire [DW-1:0] power_wd = power_masked[`CSP_PWR_DOWN] ? (power_masked & `CSP_PWR_SLEEP_CLR) : power_masked;
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      power_r <= `CSP_RST_POWER;
    end else if (warm) begin
      // Only the power-on flag survives a warm reset
      power_r <= power_r & `CSP_PWR_WARM_MASK;
    end else if (wr_power) begin
      power_r <= power_wd;
    end else if (wake_evt && state_r != ST_RUN) begin
      power_r[`CSP_PWR_DOWN] <= 1'b0;
      power_r[`CSP_PWR_SLEEP] <= 1'b0;
    end
  end
  // ****************************************
  // Sleep state machine
  // ****************************************
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (wr_power && wd[`CSP_PWR_DOWN]) state_nxt = ST_DOWN;
        else if (wr_power && wd[`CSP_PWR_SLEEP]) state_nxt = ST_IDLE;
      end
      ST_IDLE: begin
        if (wake_evt) state_nxt = ST_RUN;
      end
      ST_DOWN: begin
        // Straight back to run, never through idle
        if (wake_evt) state_nxt = ST_RUN;
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ST_RUN;
    end else if (warm) begin
      state_r <= ST_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end
  assign cpu_clk_en = state_r == ST_RUN;
  assign periph_clk_en = state_r != ST_DOWN;
  assign program_counter_hold = state_r != ST_RUN;
  // ****************************************
  // Interrupts
  // ****************************************
  wire [`CSP_EV_W-1:0] ev;
  wire [`CSP_EV_W-1:0] istat_clr = wr_istat ? pwdata[`CSP_EV_W-1:0] : {`CSP_EV_W{1'b0}};
  assign ev[`CSP_EV_DOWN_ENTER] = state_r == ST_RUN && state_nxt == ST_DOWN;
  assign ev[`CSP_EV_IDLE_ENTER] = state_r == ST_RUN && state_nxt == ST_IDLE;
  assign ev[`CSP_EV_WAKE] = state_r != ST_RUN && state_nxt == ST_RUN;
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      istat_r <= {`CSP_EV_W{1'b0}};
      imask_r <= {`CSP_EV_W{1'b0}};
    end else if (warm) begin
      istat_r <= {`CSP_EV_W{1'b0}};
      imask_r <= {`CSP_EV_W{1'b0}};
    end else begin
      // Set beats a simultaneous clear
      istat_r <= (istat_r & ~istat_clr) | ev;
      if (wr_imask) imask_r <= pwdata[`CSP_EV_W-1:0];
    end
  end
  assign irq = |(istat_r & imask_r);
  // ****************************************
  // Read mux
  // ****************************************
  wire serial_bit7 = power_r[`CSP_PWR_FSEL] ? framing_err_in : serial_mode_hi_in;
  always @* begin
    hit = 1'b1;
    prdata = 32'h00000000;
    if (sel_port) begin
      prdata[DW-1:0] = port_latch_q;
    end else if (sel_stack) begin
      prdata[DW-1:0] = stack_ptr_r;
    end else if (sel_ptr_lo) begin
      prdata[DW-1:0] = ptr_lo_act;
    end else if (sel_ptr_hi) begin
      prdata[DW-1:0] = ptr_hi_act;
    end else if (sel_aux) begin
      prdata[0] = ptr_sel_r;
    end else if (sel_reload) begin
      prdata[DW-1:0] = reload_q;
    end else if (sel_power) begin
      prdata[DW-1:0] = power_r & `CSP_PWR_WMASK;
    end else if (sel_stk_cmd) begin
      prdata[DW-1:0] = last_push_r;
    end else if (sel_sleep) begin
      prdata[2:0] = state_r;
    end else if (sel_istat) begin
      prdata[`CSP_EV_W-1:0] = istat_r;
    end else if (sel_imask) begin
      prdata[`CSP_EV_W-1:0] = imask_r;
    end else if (sel_serial) begin
      prdata[0] = serial_bit7;
    end else begin
      hit = 1'b0;
    end
  end
  // ****************************************
  // Outputs
  // ****************************************
  assign port_out = port_latch_q;
  // No guard on the reload value: the prescaler lives elsewhere
  assign wakeup_reload = reload_q;
  assign baud_double = power_r[`CSP_PWR_BAUD];
  assign framing_sel = power_r[`CSP_PWR_FSEL];
  assign stack_wr_addr = last_push_r;
endmodule // csp_core_sfr

// >>> verif/csp_sfr_properties.sv
`timescale 1ns/1ps
`include "csp_map.vh"
// ****************************************
// Checker on the register bank ports
// ****************************************
module csp_sfr_properties (
  input wire ref_clk, // Clock
  input wire arst_n, // Power-on reset
  input wire warm_rst_n, // Other resets
  input wire psel, // Select
  input wire penable, // Enable
  input wire pwrite, // Direction
  input wire [9:0] paddr, // Address
  input wire [31:0] pwdata, // Write data
  input wire wake_evt, // Wake request
  input wire [7:0] port_out, // Port latch
  input wire [7:0] wakeup_reload, // Reload byte
  input wire baud_double, // Baud doubling
  input wire framing_sel, // Bit 7 select
  input wire cpu_clk_en, // CPU gate
  input wire periph_clk_en, // Peripheral gate
  input wire program_counter_hold // Counter hold
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  sequence s_wr;
    psel && penable && pwrite && warm_rst_n;
  endsequence
  sequence s_pwr_wr;
    s_wr ##0 paddr == {`CSP_IDX_POWER, `CSP_WORD_PAD};
  endsequence
  a_down_stops_clocks: assert property (s_pwr_wr ##0 pwdata[`CSP_PWR_DOWN]
    |=> !cpu_clk_en && !periph_clk_en && program_counter_hold)
    else $error("power-down left a clock running");
  a_idle_cpu_only: assert property (s_pwr_wr ##0 pwdata[1:0] == 2'h1
    |=> !cpu_clk_en && periph_clk_en && program_counter_hold)
    else $error("idle gated the wrong clocks");
  a_wake_resumes: assert property (!cpu_clk_en && wake_evt && warm_rst_n && !(psel && penable && pwrite)
    |=> cpu_clk_en && periph_clk_en && !program_counter_hold)
    else $error("wake did not resume");
  a_down_holds: assert property (!periph_clk_en && !wake_evt && warm_rst_n && !(psel && penable && pwrite)
    |=> !periph_clk_en)
    else $error("power-down left without wake");
  a_baud_follows: assert property (s_pwr_wr |=> baud_double == $past(pwdata[7]) && framing_sel == $past(pwdata[6]))
    else $error("serial control bits not stored");
  a_port_write: assert property (s_wr ##0 paddr == {`CSP_IDX_PORT_LATCH, `CSP_WORD_PAD}
    |=> port_out == $past(pwdata[7:0]))
    else $error("port latch not written");
  a_reload_write: assert property (s_wr ##0 paddr == {`CSP_IDX_RELOAD, `CSP_WORD_PAD}
    |=> wakeup_reload == $past(pwdata[7:0]))
    else $error("reload byte not written");
  a_warm_defaults: assert property (!warm_rst_n
    |=> port_out == `CSP_RST_PORT_LATCH && wakeup_reload == `CSP_RST_ZERO && cpu_clk_en)
    else $error("warm reset values wrong");
endmodule // csp_sfr_properties

bind csp_core_sfr csp_sfr_properties u_csp_sfr_properties (.*);

// >>> verif/testbench.sv
`timescale 1ns/1ps
// ****************************************
// Bench
// ****************************************
module testbench;
  logic ref_clk = 0, arst_n = 0, warm_rst_n = 1, psel = 0, penable = 0, pwrite = 0, wake_evt = 0;
  logic serial_mode_hi_in = 1, framing_err_in = 0, err;
  logic [9:0] paddr = 0;
  logic [31:0] pwdata = 0, q;
  wire pready, pslverr, baud_double, framing_sel, cpu_clk_en, periph_clk_en, program_counter_hold, irq;
  wire [31:0] prdata;
  wire [7:0] port_out, wakeup_reload, stack_wr_addr;
  wire [15:0] data_pointer;
  int fails = 0, num_checks = 0;
  // Row: write flag, address, write byte, expected byte
  logic [24:0] rows [12] = '{25'h08000FF, 25'h0810007, 25'h0820000, 25'h0830000, 25'h0860000,
    25'h0870010, 25'h180A5A5, 25'h1813C3C, 25'h1821212, 25'h1833434, 25'h186FEFE, 25'h187ECCC};
  csp_core_sfr u_csp_core_sfr (.*);
  initial forever #25 ref_clk = ~ref_clk;
  task give_verdict;
    if (fails == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input bit ok, input string m);
    num_checks++;
    if (!ok) begin
      fails++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task apb(input bit w, input [7:0] a, input [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk); psel <= 1; penable <= 0; pwrite <= w; paddr <= {a, 2'b00}; pwdata <= d;
    @(posedge ref_clk); penable <= 1;
    do begin
      @(posedge ref_clk); n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      $display("mismatch at %0t: no ready", $time);
    end
    q = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task rd(input [7:0] a, input [31:0] e, input string m);
    apb(0, a, 0);
    chk(q === e, m);
  endtask
  task wake;
    @(posedge ref_clk) wake_evt <= 1;
    @(posedge ref_clk) wake_evt <= 0;
  endtask
  initial begin
    #100000; fails++; give_verdict;
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    arst_n <= 1;
    foreach (rows[i]) begin
      if (rows[i][24]) apb(1, rows[i][23:16], {24'h0, rows[i][15:8]});
      rd(rows[i][23:16], {24'h0, rows[i][7:0]}, "register readback");
    end
    @(negedge ref_clk);
    chk(data_pointer === 16'h3412 && baud_double === 1'b1 && framing_sel === 1'b1, "pointer or baud");
    rd(8'h94, 0, "framing flag view");
    apb(1, 8'h84, 1); @(negedge ref_clk);
    chk(data_pointer === 16'h0000, "secondary pointer");
    apb(1, 8'h82, 32'h56); apb(1, 8'h84, 0); @(negedge ref_clk);
    chk(data_pointer === 16'h3412, "primary pointer kept");
    @(posedge ref_clk) warm_rst_n <= 0;
    @(posedge ref_clk) warm_rst_n <= 1;
    rd(8'h87, 0, "warm reset power control");
    rd(8'h94, 1, "mode bit view");
    apb(1, 8'h90, 32'h100); @(negedge ref_clk);
    chk(stack_wr_addr === 8'h08, "push address");
    apb(1, 8'h90, 32'h200);
    rd(8'h81, 32'h07, "pop");
    apb(1, 8'h87, 3); @(negedge ref_clk);
    chk(cpu_clk_en === 1'b0 && periph_clk_en === 1'b0 && program_counter_hold === 1'b1 && irq === 1'b0, "power-down");
    rd(8'h91, 4, "power-down state");
    apb(1, 8'h93, 7); @(negedge ref_clk);
    chk(irq === 1'b1, "unmasked interrupt");
    wake;
    rd(8'h87, 0, "power-down bit cleared");
    apb(1, 8'h87, 1); @(negedge ref_clk);
    chk(cpu_clk_en === 1'b0 && periph_clk_en === 1'b1 && program_counter_hold === 1'b1, "idle");
    wake;
    rd(8'h87, 0, "idle bit cleared");
    rd(8'h92, 7, "event status");
    apb(1, 8'h92, 7); @(negedge ref_clk);
    chk(irq === 1'b0, "status cleared");
    apb(1, 8'hA0, 32'h55);
    rd(8'hA0, 0, "unmapped read");
    chk(err === 1'b1, "unmapped error");
    @(posedge ref_clk) arst_n <= 0;
    @(posedge ref_clk) arst_n <= 1;
    rd(8'h87, 32'h10, "power-on flag");
    give_verdict;
  end
endmodule // testbench
